// >>> oim_defines.svh
// Purpose: Constants of the output inversion mask block.
// Assumes: Register numbers are the controller's own register numbers.
// Notes:   Only the top nibble of the mask for outputs 17 to 32 is implemented.
`ifndef OIM_DEFINES_SVH
`define OIM_DEFINES_SVH

// Register numbers of the mask registers.
`define OIM_REG_MASK_17_32 16'h114A
`define OIM_REG_MASK_33_48 16'h114B
`define OIM_REG_MASK_49_64 16'h114C
`define OIM_REG_MASK_65_80 16'h114D
`define OIM_REG_MASK_81_96 16'h114E

// Reset value of every mask register.
`define OIM_MASK_RESET 16'h0000

// Bits implemented in the mask for outputs 17 to 32 (b12 to b15).
`define OIM_MASK_17_32_IMPL 16'hF000

// Bits implemented in every other mask register.
`define OIM_MASK_FULL_IMPL 16'hFFFF

// Number of mask registers held by the block.
`define OIM_NUM_MASKS 5

// Index of the last mask register.
`define OIM_LAST_IDX 3'h4

// Number of outputs below output 17, which pass unchanged.
`define OIM_UNMASKED_LOW 16

`endif

// >>> oim_mask_bank.sv
// Purpose: Holds the mask words with one write port and one registered read port.
// Assumes: Write data arrive already trimmed to the implemented bits.
// Notes:   mask_next_flat forwards a write so outputs can follow one cycle later.
`timescale 1ns/100ps
`include "oim_defines.svh"

module oim_mask_bank #(
  parameter int WORDS = `OIM_NUM_MASKS,
  parameter int WIDTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_idx,
  input  wire logic [WIDTH-1:0]       wr_data,
  input  wire logic                   rd_en,
  input  wire logic [2:0]             rd_idx,
  output logic      [WIDTH-1:0]       rd_data,
  output logic      [WORDS*WIDTH-1:0] mask_next_flat
);

  logic [WIDTH-1:0] mem_reg [WORDS];
  logic [WIDTH-1:0] mem_next [WORDS];

  // Next contents: the addressed word takes the write data.
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      mem_next[i] = (wr_en && (wr_idx == 3'(i))) ? wr_data : mem_reg[i];
      mask_next_flat[i*WIDTH +: WIDTH] = mem_next[i];
    end
  end

  // Mask storage, cleared by reset before the restore fills it.
  always_ff @(posedge clk) begin
    for (int i = 0; i < WORDS; i++) begin
      mem_reg[i] <= srst ? `OIM_MASK_RESET : mem_next[i];
    end
  end

  // Read data register; no read or an unmapped read returns zero.
  always_ff @(posedge clk) begin
    if (srst || !rd_en) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule

// >>> oim_nv_store.sv
// Purpose: Behavioural non-volatile store behind the mask block.
// Assumes: One read outstanding; writes taken every cycle.
// Notes:   Contents survive a reset of the block.
`timescale 1ns/100ps

module oim_nv_store (
  input  wire logic        clk,
  input  wire logic        nv_wr,
  input  wire logic        nv_rd,
  input  wire logic [15:0] nv_addr,
  input  wire logic [15:0] nv_wdata,
  input  wire logic [2:0]  lat,
  output logic      [15:0] nv_rdata,
  output logic             nv_rvalid
);
  logic [15:0] mem [5];
  logic [15:0] off;
  logic [2:0]  idx;
  logic [3:0]  cnt;
  assign off = nv_addr - 16'h114A;
  // Power-up contents, distinct in every word.
  initial begin
    mem = '{16'hFFFF, 16'h1234, 16'h8001, 16'h00F0, 16'h5A5A};
    cnt = 4'h0;
    nv_rvalid = 1'b0;
    nv_rdata = 16'h0000;
  end
  // Takes writes, answers a read after lat idle cycles, and scrambles data when idle.
  always @(posedge clk) begin
    nv_rvalid <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (nv_wr) mem[off[2:0]] <= nv_wdata;
    if (nv_rd) begin
      idx <= off[2:0];
      cnt <= {1'b0, lat} + 4'h1;
    end else if (cnt == 4'h1) begin
      nv_rvalid <= 1'b1;
      nv_rdata <= mem[idx];
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// >>> oim_pkg.sv
// Purpose: Types and decode helpers of the output inversion mask block.
// Assumes: oim_defines.svh is on the include path.
// Notes:   Mask index 0 is the 17 to 32 mask, index 4 the 81 to 96 mask.
`include "oim_defines.svh"

package oim_pkg;

  typedef logic [15:0] oim_word_t;
  typedef logic [2:0]  oim_idx_t;

  // Sequencer states: restore from non-volatile store, then run.
  typedef enum logic [1:0] {
    OIM_RESTORE_REQ,
    OIM_RESTORE_WAIT,
    OIM_RUN
  } oim_state_e;

  // True when a register number names one of the mask registers.
  function automatic logic oim_addr_hit(input oim_word_t addr);
    oim_addr_hit = (addr >= `OIM_REG_MASK_17_32) && (addr <= `OIM_REG_MASK_81_96);
  endfunction

  // Mask index of a register number; meaningful only on a hit.
  function automatic oim_idx_t oim_addr_to_idx(input oim_word_t addr);
    oim_word_t diff;
    diff = addr - `OIM_REG_MASK_17_32;
    oim_addr_to_idx = diff[2:0];
  endfunction

  // Register number of a mask index.
  function automatic oim_word_t oim_idx_to_addr(input oim_idx_t idx);
    oim_idx_to_addr = `OIM_REG_MASK_17_32 + {13'h0000, idx};
  endfunction

  // Bits of a mask register that are implemented; the rest read zero.
  function automatic oim_word_t oim_impl_bits(input oim_idx_t idx);
    oim_impl_bits = (idx == 3'h0) ? `OIM_MASK_17_32_IMPL : `OIM_MASK_FULL_IMPL;
  endfunction

endpackage

// >>> oim_top.sv
// Purpose: Inverts controller outputs 29 to 96 by per-bit masks before the drivers.
// Assumes: One register request per cycle; the store accepts every write at once.
// Notes:   Outputs 1 to 28 pass unchanged; their masks live elsewhere.
`timescale 1ns/100ps
`include "oim_defines.svh"

module oim_top
  import oim_pkg::*;
#(
  parameter int NUM_OUTPUTS = 96
) (
  input  wire logic                   CORE_CLK,
  input  wire logic                   SRST,
  input  wire oim_pkg::oim_word_t     REG_ADDR,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  input  wire oim_pkg::oim_word_t     REG_WDATA,
  output oim_pkg::oim_word_t          REG_RDATA,
  output logic                        REG_RVALID,
  output logic                        REG_ERR,
  output logic                        REG_READY,
  input  wire logic [NUM_OUTPUTS-1:0] OUT_STATE,
  output logic      [NUM_OUTPUTS-1:0] OUT_DRIVE,
  output logic                        NV_WR,
  output logic                        NV_RD,
  output oim_pkg::oim_word_t          NV_ADDR,
  output oim_pkg::oim_word_t          NV_WDATA,
  input  wire oim_pkg::oim_word_t     NV_RDATA,
  input  wire logic                   NV_RVALID
);

  import oim_pkg::*;

  localparam int MASK_BITS = `OIM_NUM_MASKS * 16;

  oim_state_e             state_reg;
  oim_state_e             state_next;
  oim_idx_t               restore_idx_reg;
  oim_idx_t               restore_idx_next;
  logic                   rvalid_reg;
  logic                   err_reg;
  logic                   ready_reg;
  logic                   nv_wr_reg;
  logic                   nv_rd_reg;
  oim_word_t              nv_addr_reg;
  oim_word_t              nv_wdata_reg;
  logic [NUM_OUTPUTS-1:0] drive_reg;
  logic [NUM_OUTPUTS-1:0] drive_next;

  wire logic             running;
  wire logic             addr_hit;
  wire oim_idx_t         addr_idx;
  wire logic             sw_wr;
  wire logic             sw_rd;
  wire logic             sw_bad;
  wire logic             restore_wr;
  wire logic             bank_wr;
  wire oim_idx_t         bank_wr_idx;
  wire oim_word_t        bank_wr_raw;
  wire oim_word_t        bank_wr_data;
  wire oim_word_t        bank_rd_data;
  wire logic [MASK_BITS-1:0]   mask_next_flat;
  wire logic [NUM_OUTPUTS-1:0] mask_all;

  // Request decode: registers answer only once the restore has finished.
  assign running  = (state_reg == OIM_RUN);
  assign addr_hit = oim_addr_hit(REG_ADDR);
  assign addr_idx = oim_addr_to_idx(REG_ADDR);
  assign sw_wr    = running && REG_WR && addr_hit;
  assign sw_rd    = running && REG_RD && !REG_WR;
  assign sw_bad   = running && (REG_WR || REG_RD) && !addr_hit;

  // Bank write selection: restored words during start-up, software writes after.
  assign restore_wr   = (state_reg == OIM_RESTORE_WAIT) && NV_RVALID;
  assign bank_wr      = restore_wr || sw_wr;
  assign bank_wr_idx  = restore_wr ? restore_idx_reg : addr_idx;
  assign bank_wr_raw  = restore_wr ? NV_RDATA : REG_WDATA;
  // Unimplemented low bits of the 17 to 32 mask are dropped here.
  assign bank_wr_data = bank_wr_raw & oim_impl_bits(bank_wr_idx);

  // Mask words: index 0 covers outputs 17-32, 1 to 4 cover 33-96.
  oim_mask_bank #(
    .WORDS (`OIM_NUM_MASKS),
    .WIDTH (16)
  ) u_bank (
    .clk            (CORE_CLK),
    .srst           (SRST),
    .wr_en          (bank_wr),
    .wr_idx         (bank_wr_idx),
    .wr_data        (bank_wr_data),
    .rd_en          (sw_rd && addr_hit),
    .rd_idx         (addr_idx),
    .rd_data        (bank_rd_data),
    .mask_next_flat (mask_next_flat)
  );

  // Full mask over all outputs; outputs 1 to 16 carry no mask bits.
  // Word 1 lands on outputs 33-48, word 2 on 49-64, word 3 on 65-80, word 4 on 81-96.
  assign mask_all = {mask_next_flat, {`OIM_UNMASKED_LOW{1'b0}}};

  // A set mask bit flips the output, a clear bit leaves it alone.
  // The forwarded mask makes a write show on the outputs one cycle later.
  assign drive_next = OUT_STATE ^ mask_all;

  // Restore sequencer: fetch each mask word from the store after reset.
  always_comb begin
    state_next       = state_reg;
    restore_idx_next = restore_idx_reg;
    case (state_reg)
      OIM_RESTORE_REQ: begin
        state_next = OIM_RESTORE_WAIT;
      end
      OIM_RESTORE_WAIT: begin
        if (NV_RVALID) begin
          if (restore_idx_reg == `OIM_LAST_IDX) begin
            state_next = OIM_RUN;
          end else begin
            restore_idx_next = restore_idx_reg + 3'h1;
            state_next       = OIM_RESTORE_REQ;
          end
        end
      end
      OIM_RUN: begin
        state_next = OIM_RUN;
      end
      default: begin
        state_next       = OIM_RESTORE_REQ;
        restore_idx_next = 3'h0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg       <= OIM_RESTORE_REQ;
      restore_idx_reg <= 3'h0;
    end else begin
      state_reg       <= state_next;
      restore_idx_reg <= restore_idx_next;
    end
  end

  // Store traffic: one read per word at start-up, one write per software write to a mask register.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      nv_rd_reg    <= 1'b0;
      nv_wr_reg    <= 1'b0;
      nv_addr_reg  <= 16'h0000;
      nv_wdata_reg <= 16'h0000;
    end else begin
      nv_rd_reg <= (state_reg == OIM_RESTORE_REQ);
      nv_wr_reg <= sw_wr;
      if (state_reg == OIM_RESTORE_REQ) begin
        nv_addr_reg <= oim_idx_to_addr(restore_idx_reg);
      end else if (sw_wr) begin
        nv_addr_reg  <= REG_ADDR;
        nv_wdata_reg <= bank_wr_data;
      end
    end
  end

  // Answer flags of the register port.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rvalid_reg <= 1'b0;
      err_reg    <= 1'b0;
      ready_reg  <= 1'b0;
    end else begin
      rvalid_reg <= sw_rd;
      err_reg    <= sw_bad;
      ready_reg  <= (state_next == OIM_RUN);
    end
  end

  // Driven outputs; all held low while in reset.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  // Port drive, each straight from a register.
  assign REG_RDATA  = bank_rd_data;
  assign REG_RVALID = rvalid_reg;
  assign REG_ERR    = err_reg;
  assign REG_READY  = ready_reg;
  assign OUT_DRIVE  = drive_reg;
  assign NV_WR      = nv_wr_reg;
  assign NV_RD      = nv_rd_reg;
  assign NV_ADDR    = nv_addr_reg;
  assign NV_WDATA   = nv_wdata_reg;

endmodule

// >>> oim_top_assertions.sv
// Purpose: Port assertions of the output mask block.
// Assumes: One clock and a synchronous reset.
// Notes:   Attached by the bind below the module.
`timescale 1ns/100ps

module oim_top_assertions
  import oim_pkg::*;
#(
  parameter int NUM_OUTPUTS = 96
) (
  input wire logic                   CORE_CLK,
  input wire logic                   SRST,
  input wire oim_pkg::oim_word_t     REG_ADDR,
  input wire logic                   REG_WR,
  input wire logic                   REG_RD,
  input wire oim_pkg::oim_word_t     REG_WDATA,
  input wire logic                   REG_RVALID,
  input wire logic                   REG_ERR,
  input wire logic                   REG_READY,
  input wire logic [NUM_OUTPUTS-1:0] OUT_STATE,
  input wire logic [NUM_OUTPUTS-1:0] OUT_DRIVE,
  input wire logic                   NV_WR,
  input wire oim_pkg::oim_word_t     NV_ADDR
);
  // Accepted requests and the decode of the mapped numbers.
  wire logic wr = REG_READY && REG_WR;
  wire logic rd = REG_READY && REG_RD && !REG_WR;
  wire logic hit = REG_ADDR >= 16'h114A && REG_ADDR <= 16'h114E;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  // Outputs follow the state one cycle later, through the mask just written.
  chk_low_pass: assert property (
    !$past(SRST) |-> OUT_DRIVE[27:0] == $past(OUT_STATE[27:0])) else $error("low outputs moved");
  chk_mask_29_32: assert property (
    wr && REG_ADDR == 16'h114A |=> OUT_DRIVE[31:28] ==
    ($past(OUT_STATE[31:28]) ^ $past(REG_WDATA[15:12]))) else $error("outputs 29-32 wrong");
  chk_mask_33_48: assert property (
    wr && REG_ADDR == 16'h114B |=> OUT_DRIVE[47:32] ==
    ($past(OUT_STATE[47:32]) ^ $past(REG_WDATA))) else $error("outputs 33-48 wrong");
  chk_mask_49_64: assert property (
    wr && REG_ADDR == 16'h114C |=> OUT_DRIVE[63:48] ==
    ($past(OUT_STATE[63:48]) ^ $past(REG_WDATA))) else $error("outputs 49-64 wrong");
  chk_mask_65_80: assert property (
    wr && REG_ADDR == 16'h114D |=> OUT_DRIVE[79:64] ==
    ($past(OUT_STATE[79:64]) ^ $past(REG_WDATA))) else $error("outputs 65-80 wrong");
  chk_mask_81_96: assert property (
    wr && REG_ADDR == 16'h114E |=> OUT_DRIVE[95:80] ==
    ($past(OUT_STATE[95:80]) ^ $past(REG_WDATA))) else $error("outputs 81-96 wrong");
  chk_store_mirror: assert property (
    wr && hit |=> NV_WR && NV_ADDR == $past(REG_ADDR)) else $error("write not mirrored");
  chk_read_answer: assert property (
    rd && hit |=> REG_RVALID && !REG_ERR) else $error("read not answered");
  chk_ready_holds: assert property (
    REG_READY |=> REG_READY) else $error("ready dropped");
endmodule

bind oim_top oim_top_assertions #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_chk (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR), .REG_READY(REG_READY),
  .OUT_STATE(OUT_STATE), .OUT_DRIVE(OUT_DRIVE), .NV_WR(NV_WR), .NV_ADDR(NV_ADDR));

// >>> oim_top_tb.sv
// Purpose: Self-checking bench of the output mask block.
// Assumes: The store model answers every restore read.
// Notes:   The expected mask image is kept in inv.
`timescale 1ns/100ps

module oim_top_tb;
  import oim_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  oim_word_t   addr = 16'h0000;
  oim_word_t   wdata = 16'h0000;
  logic [95:0] state = 96'h0;
  logic [2:0]  lat = 3'h0;
  oim_word_t   rdata, nv_addr, nv_wdata, nv_rdata;
  logic        rvalid, rerr, ready, nv_wr, nv_rd, nv_rvalid;
  logic [95:0] drive, inv;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  oim_top dut (
    .CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr_en), .REG_RD(rd_en),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_ERR(rerr),
    .REG_READY(ready), .OUT_STATE(state), .OUT_DRIVE(drive), .NV_WR(nv_wr), .NV_RD(nv_rd),
    .NV_ADDR(nv_addr), .NV_WDATA(nv_wdata), .NV_RDATA(nv_rdata), .NV_RVALID(nv_rvalid));
  oim_nv_store store (
    .clk(clk), .nv_wr(nv_wr), .nv_rd(nv_rd), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .lat(lat), .nv_rdata(nv_rdata), .nv_rvalid(nv_rvalid));

  // Clock and a watchdog that cuts a hung run short.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  // Counts a comparison and reports a mismatch.
  task cmp(input logic [111:0] g, input logic [111:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Expected image and decode of a register number.
  // Offset from the first mask number, taken in 16 bits so a number below wraps high.
  function automatic int reg_off(input oim_word_t a);
    oim_word_t d;
    d = a - 16'h114A;
    reg_off = int'(d);
  endfunction
  function automatic logic unm(input oim_word_t a);
    unm = reg_off(a) > 4;
  endfunction
  function automatic oim_word_t mval(input oim_word_t a);
    int o;
    o = reg_off(a);
    mval = (o == 0) ? {inv[31:28], 12'h000} : (o < 5) ? inv[16*o+16 +: 16] : 16'h0000;
  endfunction
  task put(input oim_word_t a, input oim_word_t d);
    int o;
    o = reg_off(a);
    if (o == 0) inv[31:28] = d[15:12];
    else if (o < 5) inv[16*o+16 +: 16] = d;
  endtask

  // Register write; checks outputs, error pulse and store mirror a cycle later.
  task wr(input oim_word_t a, input oim_word_t d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    put(a, d);
    #1;
    cmp({rvalid, rerr, nv_wr, drive}, {1'b0, unm(a), !unm(a), state ^ inv});
    @(posedge clk);
  endtask

  // Register read; checks the one-cycle answer.
  task rd(input oim_word_t a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp({rvalid, rerr, rdata}, {1'b1, unm(a), mval(a)});
    @(posedge clk);
  endtask

  // New output states; checks the driven outputs one cycle later.
  task drv(input logic [95:0] s);
    state <= s;
    @(posedge clk);
    #1;
    cmp(drive, s ^ inv);
    @(posedge clk);
  endtask

  // Reset, snapshot of the store, a write refused before ready, wait for restore.
  task boot(input logic [2:0] l);
    lat <= l;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    // Snapshot taken once all earlier writes have landed in the store.
    for (int i = 0; i < 5; i++) put(16'h114A + i[15:0], store.mem[i]);
    srst <= 1'b0;
    addr <= 16'h114B;
    wdata <= 16'hFFFF;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    while (ready !== 1'b1) @(posedge clk);
  endtask

  // Verdict and end of the run.
  task end_of_test;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial begin
    inv = 96'h0;
    boot(3'h0);
    for (int i = 0; i < 7; i++) rd(16'h1149 + i[15:0]);
    drv({6{16'h9E37}});
    for (int i = 0; i < 6; i++) wr(16'h114A + i[15:0], 16'hC3A5 ^ i[15:0]);
    wr(16'h114D, 16'h0001);
    wr(16'h114E, 16'h8000);
    wr(16'h114C, 16'h7FFE);
    wr(16'h114A, 16'h5FFF);
    // A read raised together with a write is dropped, and the write still lands.
    rd_en <= 1'b1;
    wr(16'h114B, 16'h0F0F);
    for (int i = 0; i < 7; i++) rd(16'h1149 + i[15:0]);
    drv(96'h0);
    drv(~96'h0);
    boot(3'h5);
    for (int i = 0; i < 7; i++) rd(16'h1149 + i[15:0]);
    drv({6{16'hA55A}});
    end_of_test();
  end
endmodule
